// ---- include/oma_pkg.sv ----
package oma_pkg;

    // Operation modes, panel mode is the reset default
    typedef enum logic [1:0] {
        OMA_PANEL,
        OMA_CONTACT,
        OMA_SERIAL
    } oma_mode_e;

    // Panel mode-select codes
    localparam logic [1:0] OMA_SEL_PANEL   = 2'h0;
    localparam logic [1:0] OMA_SEL_CONTACT = 2'h1;
    localparam logic [1:0] OMA_SEL_SERIAL  = 2'h2;

    // Synchroniser depth for pin inputs
    localparam int OMA_SYNC_STAGES = 3;

    // Setpoint width
    localparam int OMA_SETPT_W = 16;

endpackage

// ---- verilog/oma_pin_sync.sv ----
`timescale 1ns/1ns
module oma_pin_sync
    import oma_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    // Pin side
    input  wire logic [WIDTH-1:0] pin_in,
    // Filtered level
    output logic      [WIDTH-1:0] level_out
);

    initial begin
        if (WIDTH < 1) begin
            $error("oma_pin_sync: WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // Accept a change once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            assign level_next[gi] = (stage2_reg[gi] == stage3_reg[gi]) ? stage3_reg[gi]
                                                                       : level_reg[gi];
        end
    endgenerate

    // Three-stage chain, first stage only feeds the second
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg  <= '0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= level_next;
        end
    end

    assign level_out = level_reg;

endmodule

// ---- verilog/oma_arbiter.sv ----
`timescale 1ns/1ns
module oma_arbiter
    import oma_pkg::*;
#(
    parameter int SETPT_W = OMA_SETPT_W
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // Operator panel
    input  wire logic               panel_mode_wr,
    input  wire logic [1:0]         panel_mode_sel,
    input  wire logic               panel_run_wr,
    input  wire logic               panel_run_val,
    input  wire logic               panel_setpt_wr,
    input  wire logic [SETPT_W-1:0] panel_setpt_val,
    // Serial host, same clock
    input  wire logic               ser_mode_req,
    input  wire logic               ser_run_wr,
    input  wire logic               ser_run_val,
    input  wire logic               ser_setpt_wr,
    input  wire logic [SETPT_W-1:0] ser_setpt_val,
    // Contact pins
    input  wire logic               contact_run_pin,
    input  wire logic               ext_switch_pin,
    // Mode indication
    output logic                    panel_mode_display,
    output logic                    contact_input_mode,
    output logic                    serial_mode_display,
    // Results
    output logic                    run_reg_out,
    output logic [SETPT_W-1:0]      setpt_out,
    output logic                    ext_switch_level,
    output logic                    contact_run_level,
    output logic                    panel_rejected,
    output logic                    ser_rejected
);

    initial begin
        if (SETPT_W < 1) begin
            $error("oma_arbiter: SETPT_W must be at least 1");
        end
    end

    oma_mode_e          mode_reg;
    oma_mode_e          mode_next;
    logic               req_prev_reg;
    logic               run_reg;
    logic               run_next;
    logic [SETPT_W-1:0] setpt_reg;
    logic [SETPT_W-1:0] setpt_next;
    logic               contact_prev_reg;
    logic               panel_rej_reg;
    logic               ser_rej_reg;
    logic [1:0]         pins_sync;

    // Contact pins cross into the clock domain; one synchroniser for both pins
    oma_pin_sync #(
        .WIDTH     (2)
    ) u_sync (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .pin_in    ({ext_switch_pin, contact_run_pin}),
        .level_out (pins_sync)
    );

    // Mode request edge, ignored while held high
    wire req_rise = ser_mode_req && !req_prev_reg;

    // Panel mode selection decode
    wire panel_sel_ok = (panel_mode_sel == OMA_SEL_PANEL)
                     || (panel_mode_sel == OMA_SEL_CONTACT)
                     || (panel_mode_sel == OMA_SEL_SERIAL);

    // Source permissions per mode
    wire in_panel   = (mode_reg == OMA_PANEL);
    wire in_contact = (mode_reg == OMA_CONTACT);
    wire in_serial  = (mode_reg == OMA_SERIAL);
    wire panel_run_ok   = panel_run_wr && in_panel;
    wire panel_setpt_ok = panel_setpt_wr && (in_panel || in_contact);
    wire ser_run_ok     = ser_run_wr && in_serial;
    wire ser_setpt_ok   = ser_setpt_wr && in_serial;
    wire contact_edge   = pins_sync[0] != contact_prev_reg;
    wire contact_run_ok = contact_edge && in_contact;

    // Rejected attempts, reported as one-cycle pulses
    wire panel_rej = (panel_run_wr && !in_panel)
                  || (panel_setpt_wr && in_serial)
                  || (panel_mode_wr && !panel_sel_ok);
    wire ser_rej   = (ser_run_wr && !in_serial)
                  || (ser_setpt_wr && !in_serial);

    // Next mode: serial request edge beats a panel change
    always_comb begin
        mode_next = mode_reg;
        if (req_rise) begin
            mode_next = OMA_SERIAL;
        end else if (panel_mode_wr && panel_sel_ok) begin
            unique case (panel_mode_sel)
                OMA_SEL_CONTACT: mode_next = OMA_CONTACT;
                OMA_SEL_SERIAL:  mode_next = OMA_SERIAL;
                default:         mode_next = OMA_PANEL;
            endcase
        end
    end

    // Run state follows the one source allowed in this mode
    always_comb begin
        run_next = run_reg;
        if (panel_run_ok) begin
            run_next = panel_run_val;
        end else if (ser_run_ok) begin
            run_next = ser_run_val;
        end else if (contact_run_ok) begin
            run_next = pins_sync[0];
        end
    end

    // Setpoint follows the one source allowed in this mode
    always_comb begin
        setpt_next = setpt_reg;
        if (panel_setpt_ok) begin
            setpt_next = panel_setpt_val;
        end else if (ser_setpt_ok) begin
            setpt_next = ser_setpt_val;
        end
    end

    // State registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mode_reg         <= OMA_PANEL;
            req_prev_reg     <= 1'b0;
            run_reg          <= 1'b0;
            setpt_reg        <= '0;
            contact_prev_reg <= 1'b0;
            panel_rej_reg    <= 1'b0;
            ser_rej_reg      <= 1'b0;
        end else begin
            mode_reg         <= mode_next;
            req_prev_reg     <= ser_mode_req;
            run_reg          <= run_next;
            setpt_reg        <= setpt_next;
            contact_prev_reg <= pins_sync[0];
            panel_rej_reg    <= panel_rej;
            ser_rej_reg      <= ser_rej;
        end
    end

    // Outputs, all from flip-flops
    assign panel_mode_display  = (mode_reg == OMA_PANEL);
    assign contact_input_mode  = (mode_reg == OMA_CONTACT);
    assign serial_mode_display = (mode_reg == OMA_SERIAL);
    assign run_reg_out         = run_reg;
    assign setpt_out           = setpt_reg;
    assign ext_switch_level    = pins_sync[1];
    assign contact_run_level   = pins_sync[0];
    assign panel_rejected      = panel_rej_reg;
    assign ser_rejected        = ser_rej_reg;

endmodule

// ---- test/oma_monitor.sv ----
`timescale 1ns/1ns
module oma_monitor
    import oma_pkg::*;
#(
    parameter int SETPT_W = OMA_SETPT_W
) (
    // Clock and reset
    input wire logic               clk_sys, rstn,
    // Requests
    input wire logic               panel_mode_wr, panel_run_wr, panel_run_val,
    input wire logic               ser_mode_req, ser_run_wr, ser_setpt_wr,
    input wire logic [SETPT_W-1:0] ser_setpt_val, setpt_out,
    // Results
    input wire logic               panel_mode_display, contact_input_mode, serial_mode_display,
    input wire logic               run_reg_out, panel_rejected, ser_rejected
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Mode indication
    a_mode_one_hot: assert property (
        $onehot({panel_mode_display, contact_input_mode, serial_mode_display}))
        else $error("mode indication not one-hot");
    a_reset_panel: assert property (
        $rose(rstn) |-> panel_mode_display && !run_reg_out && setpt_out == '0)
        else $error("reset state wrong");
    a_flag_edge: assert property (
        ser_mode_req && !$past(ser_mode_req) |=> serial_mode_display)
        else $error("flag edge did not select serial mode");
    a_mode_holds: assert property (
        $past(rstn) && !panel_mode_wr && !(ser_mode_req && !$past(ser_mode_req))
        |=> $stable({panel_mode_display, contact_input_mode, serial_mode_display}))
        else $error("mode changed without a cause");
    // Source gating
    a_panel_refused: assert property (
        panel_run_wr && !panel_mode_display |=> panel_rejected)
        else $error("panel run not refused");
    a_serial_refused: assert property (
        (ser_run_wr || ser_setpt_wr) && !serial_mode_display |=> ser_rejected)
        else $error("serial write not refused");
    a_panel_run_taken: assert property (
        panel_run_wr && panel_mode_display |=> run_reg_out == $past(panel_run_val))
        else $error("panel run not taken");
    a_ser_setpt_taken: assert property (
        ser_setpt_wr && serial_mode_display |=> setpt_out == $past(ser_setpt_val))
        else $error("serial setpoint not taken");
endmodule

// ---- test/oma_contact_model.sv ----
`timescale 1ns/1ns
module oma_contact_model (
    // Requested levels
    input  wire logic want_run,
    input  wire logic want_sw,
    // Contact pins
    output logic      contact_run_pin,
    output logic      ext_switch_pin
);
    // Pins move off the clock grid, as real contacts do
    initial begin
        contact_run_pin = 1'h0;
        ext_switch_pin = 1'h0;
    end
    always @(want_run) contact_run_pin <= #7 want_run;
    always @(want_sw) ext_switch_pin <= #7 want_sw;
endmodule

// ---- test/oma_arbiter_bench.sv ----
`timescale 1ns/1ns
module oma_arbiter_bench;
    import oma_pkg::*;
    localparam int SETPT_W = OMA_SETPT_W;
    logic clk_sys = 0, rstn = 0, panel_mode_wr = 0, panel_run_wr = 0, panel_run_val = 0;
    logic panel_setpt_wr = 0, ser_mode_req = 0, ser_run_wr = 0, ser_run_val = 0;
    logic ser_setpt_wr = 0, want_run = 0, want_sw = 0, contact_run_pin, ext_switch_pin;
    logic panel_mode_display, contact_input_mode, serial_mode_display, run_reg_out;
    logic ext_switch_level, contact_run_level, panel_rejected, ser_rejected;
    logic [1:0] panel_mode_sel = 0;
    logic [SETPT_W-1:0] panel_setpt_val = 0, ser_setpt_val = 0, setpt_out, e_sp;
    logic [31:0] lf = 32'h6bfb_4947;
    bit e_run, e_rp, e_rs, prv, s1, s2, s3, lv, lvp, ce;
    int err_count = 0, tests_run = 0, m;
    oma_arbiter i_oma_arbiter (.*);
    oma_contact_model i_oma_contact_model (.want_run(want_run), .want_sw(want_sw),
        .contact_run_pin(contact_run_pin), .ext_switch_pin(ext_switch_pin));
    always #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] nx(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk1(string n, logic g, logic e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: %s got %b", $time, n, g);
        end
    endtask
    task automatic chk16(string n, logic [SETPT_W-1:0] g, logic [SETPT_W-1:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: %s got %h", $time, n, g);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One cycle: model the edge, drive new inputs, compare
    task automatic step(bit rnd, bit rs);
        @(posedge clk_sys);
        if (!rstn) begin
            {m, e_run, e_sp, e_rp, e_rs, prv} = '0;
            {s1, s2, s3, lv, lvp} = '0;
        end else begin
            e_rp = (panel_run_wr && m != 0) || (panel_setpt_wr && m == 2)
                || (panel_mode_wr && panel_mode_sel == 3);
            e_rs = (ser_run_wr || ser_setpt_wr) && m != 2;
            ce = lv != lvp;
            if (panel_run_wr && m == 0) e_run = panel_run_val;
            else if (ser_run_wr && m == 2) e_run = ser_run_val;
            else if (m == 1 && ce) e_run = lv;
            // Contact level: three stages, agreement filter, then change detect
            lvp = lv;
            if (s2 == s3) lv = s3;
            s3 = s2;
            s2 = s1;
            s1 = contact_run_pin;
            if (panel_setpt_wr && m != 2) e_sp = panel_setpt_val;
            else if (ser_setpt_wr && m == 2) e_sp = ser_setpt_val;
            if (ser_mode_req && !prv) m = 2;
            else if (panel_mode_wr && panel_mode_sel != 3) m = panel_mode_sel;
            prv = ser_mode_req;
        end
        #2;
        lf = nx(lf);
        rstn = !rs;
        panel_mode_wr = !rnd || lf[3:0] == 0;
        panel_mode_sel = rnd ? lf[5:4] : 2'h0;
        panel_run_wr = rnd && lf[6];
        panel_run_val = lf[7];
        panel_setpt_wr = rnd && lf[8];
        panel_setpt_val = lf[31:16];
        ser_run_wr = rnd && lf[9];
        ser_run_val = lf[10];
        ser_setpt_wr = rnd && lf[11];
        ser_setpt_val = ~lf[31:16];
        if (rnd && !panel_mode_wr && lf[15:13] == 0) ser_mode_req = !ser_mode_req;
        if (rs) ser_mode_req = 1'b0;
        if (rnd && lf[12] && lf[2:0] == 0) want_run = !want_run;
        #3;
        chk1("panel", panel_mode_display, m == 0);
        chk1("contact", contact_input_mode, m == 1);
        chk1("serial", serial_mode_display, m == 2);
        chk1("run", run_reg_out, e_run);
        chk16("setpt", setpt_out, e_sp);
        chk1("prej", panel_rejected, e_rp);
        chk1("srej", ser_rejected, e_rs);
    endtask
    initial begin
        #2_000_000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (16) step(0, 1);
        for (int p = 0; p < 8; p++) begin
            repeat (2) step(0, p == 4);
            want_run = p[0];
            want_sw = p[1];
            repeat (8) step(0, 0);
            chk1("swlev", ext_switch_level, want_sw);
            chk1("runlev", contact_run_level, want_run);
            repeat (300) step(1, 0);
        end
        wrap_up();
    end
endmodule
bind oma_arbiter oma_monitor #(.SETPT_W(SETPT_W)) i_oma_monitor (.*);
